// [pkg/vcr_pkg.sv]
// package for the line code violation counter and readback block
package vcr_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int VCR_CHANNELS = 14;
  localparam int VCR_CNT_W = 16;
  localparam logic [VCR_CNT_W-1:0] VCR_CNT_MAX = 16'hFFFF;
  localparam logic [VCR_CNT_W-1:0] VCR_CNT_ZERO = 16'h0000;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] VCR_OFS_CONTROL = 8'hE5;
  localparam logic [7:0] VCR_OFS_RESET_LATCH = 8'hE6;
  localparam logic [7:0] VCR_OFS_COUNT_BYTE = 8'hE8;
  localparam logic [7:0] VCR_CONTROL_RESET = 8'h00;
  localparam logic [7:0] VCR_RESET_LATCH_RESET = 8'h00;
  localparam logic [7:0] VCR_BYTE_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // host timing: reset bits are held high this long by software
  // ----------------------------------------------------------------
  localparam int VCR_CLK_MHZ = 20;
  localparam int VCR_RESET_HOLD_NS = 1000;
  localparam int VCR_RESET_HOLD_CYC = (VCR_RESET_HOLD_NS * VCR_CLK_MHZ + 999) / 1000;

  // control register, bit 7 down to bit 0
  typedef struct packed {
    logic violation_or_overflow_select;
    logic counter_readback_enable;
    logic [1:0] reserved;
    logic [3:0] counter_channel_select;
  } vcr_control_type;

  // reset and latch register, bit 7 down to bit 0
  typedef struct packed {
    logic [2:0] reserved;
    logic reset_all_counters;
    logic latch_all_channels;
    logic byte_half_select;
    logic latch_one_channel;
    logic reset_one_counter;
  } vcr_reset_latch_type;

  // register write request from the microprocessor port
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } vcr_reg_req_type;

endpackage

// [core/vcr_channel_counter.sv]
// one saturating 16-bit line code violation counter
`timescale 1ns/100ps
`default_nettype none
module vcr_channel_counter
  import vcr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic line_code_violation,
  output logic [VCR_CNT_W-1:0] count_q,
  output logic overflow
);

  // clear beats counting; at full scale the count sticks until cleared
  always_ff @(posedge sys_clk) begin
    if (rst || clear) begin
      count_q <= VCR_CNT_ZERO; // RULE_06
    end else if (line_code_violation && !overflow) begin
      count_q <= count_q + 16'h0001; // RULE_11
    end
  end

  // saturation doubles as the overflow condition
  assign overflow = (count_q == VCR_CNT_MAX); // RULE_01 RULE_02

endmodule // vcr_channel_counter
`default_nettype wire

// [core/vcr_violation_counter_readback.sv]
// violation counters with control, latch and byte-wise readback registers
// Functional notes
// RULE_01: every channel keeps a 16-bit counter; full scale raises that channel's overflow.
// RULE_02: a full counter stops at FFFFh until software resets it.
// RULE_03: monitor select picks violation activity (0) or overflow (1) for status.
// RULE_04: readback enable set exposes the selected count byte; clear reads zero.
// RULE_05: four-bit channel select picks the channel for reads and per-channel commands.
// RULE_06: global reset bit clears all counters to zero while it is set.
// RULE_07: software holds the global reset bit high one microsecond.
// RULE_08: latch bits copy all counters, or only the selected one, to holding registers.
// RULE_09: byte select picks low byte (0) or high byte (1) of held count.
// RULE_10: per-channel reset clears only the selected counter; software holds it one microsecond.
// RULE_11: counters add one per violation, never while saturated or reset.
`timescale 1ns/100ps
`default_nettype none
module vcr_violation_counter_readback
  import vcr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire vcr_reg_req_type reg_req,
  input wire logic [VCR_CHANNELS-1:0] line_code_violation,
  output logic [7:0] reg_rdata_q,
  output logic [VCR_CHANNELS-1:0] monitor_status_q
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // channel codes 14 and 15 select nothing
  function automatic logic chan_valid(input logic [3:0] sel);
    chan_valid = (32'(sel) < VCR_CHANNELS);
  endfunction

  function automatic logic wr_hit(input vcr_reg_req_type req, input logic [7:0] ofs);
    wr_hit = req.wr && (req.addr == ofs);
  endfunction

  vcr_control_type control_q;
  vcr_reset_latch_type reset_latch_q;
  logic [VCR_CHANNELS-1:0][VCR_CNT_W-1:0] count_w;
  logic [VCR_CHANNELS-1:0][VCR_CNT_W-1:0] hold_q;
  logic [VCR_CHANNELS-1:0] overflow_w;
  logic [VCR_CHANNELS-1:0] clear_w;
  logic [VCR_CNT_W-1:0] sel_hold_w;
  logic [7:0] count_byte_w;
  logic sel_ok_w;

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // reserved bits are stored and read back as written
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      control_q <= vcr_control_type'(VCR_CONTROL_RESET);
    end else if (wr_hit(reg_req, VCR_OFS_CONTROL)) begin
      control_q <= vcr_control_type'(reg_req.wdata);
    end
  end

  // reset and latch bits are levels: they act for as long as software leaves them set
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reset_latch_q <= vcr_reset_latch_type'(VCR_RESET_LATCH_RESET);
    end else if (wr_hit(reg_req, VCR_OFS_RESET_LATCH)) begin
      reset_latch_q <= vcr_reset_latch_type'(reg_req.wdata);
    end
  end

  assign sel_ok_w = chan_valid(control_q.counter_channel_select); // RULE_05

  // ----------------------------------------------------------------
  // counters and holding registers
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < VCR_CHANNELS; gi++) begin : g_chan
      // global reset or a per-channel reset aimed at this channel
      assign clear_w[gi] = reset_latch_q.reset_all_counters || // RULE_06
        (reset_latch_q.reset_one_counter && sel_ok_w &&
         control_q.counter_channel_select == 4'(gi)); // RULE_10

      vcr_channel_counter u_counter (
        .sys_clk(sys_clk),
        .rst(rst),
        .clear(clear_w[gi]),
        .line_code_violation(line_code_violation[gi]),
        .count_q(count_w[gi]),
        .overflow(overflow_w[gi])
      );

      // holding copy tracks the counter while a latch bit covers this channel
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          hold_q[gi] <= VCR_CNT_ZERO;
        end else if (reset_latch_q.latch_all_channels ||
                     (reset_latch_q.latch_one_channel && sel_ok_w &&
                      control_q.counter_channel_select == 4'(gi))) begin
          hold_q[gi] <= count_w[gi]; // RULE_08
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // readback path
  // ----------------------------------------------------------------
  // reads come from the held copy, so a multi-byte read is not torn by counting
  always_comb begin
    sel_hold_w = VCR_CNT_ZERO;
    if (sel_ok_w) begin
      sel_hold_w = hold_q[control_q.counter_channel_select];
    end
    count_byte_w = VCR_BYTE_ZERO;
    if (control_q.counter_readback_enable && sel_ok_w) begin // RULE_04
      count_byte_w = reset_latch_q.byte_half_select ? sel_hold_w[15:8] : sel_hold_w[7:0]; // RULE_09
    end
  end

  // read data follows the address one cycle later; unmapped offsets read zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata_q <= VCR_BYTE_ZERO;
    end else begin
      case (reg_req.addr)
        VCR_OFS_CONTROL: reg_rdata_q <= control_q;
        VCR_OFS_RESET_LATCH: reg_rdata_q <= reset_latch_q;
        VCR_OFS_COUNT_BYTE: reg_rdata_q <= count_byte_w; // RULE_04
        default: reg_rdata_q <= VCR_BYTE_ZERO;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // per-channel status bit
  // ----------------------------------------------------------------
  // activity mode shows the violation of the previous cycle only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      monitor_status_q <= '0;
    end else if (control_q.violation_or_overflow_select) begin
      monitor_status_q <= overflow_w; // RULE_03 RULE_01
    end else begin
      monitor_status_q <= line_code_violation; // RULE_03
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  generate
    for (gi = 0; gi < VCR_CHANNELS; gi++) begin : g_chk
      property p_saturate_hold;
        (count_w[gi] == VCR_CNT_MAX) && !clear_w[gi] |=> (count_w[gi] == VCR_CNT_MAX);
      endproperty
      a_saturate_hold: assert property (p_saturate_hold) else $error("full counter moved"); // RULE_02

      property p_count_step;
        line_code_violation[gi] && !clear_w[gi] && (count_w[gi] != VCR_CNT_MAX)
          |=> (count_w[gi] == $past(count_w[gi]) + 16'h0001);
      endproperty
      a_count_step: assert property (p_count_step) else $error("counter missed a violation"); // RULE_11

      property p_idle_stable;
        !line_code_violation[gi] && !clear_w[gi] |=> $stable(count_w[gi]);
      endproperty
      a_idle_stable: assert property (p_idle_stable) else $error("counter moved without cause"); // RULE_11

      // status flop takes the overflow on the edge that samples it, so one cycle of lag
      property p_ovf_status;
        control_q.violation_or_overflow_select && (count_w[gi] == VCR_CNT_MAX) && !clear_w[gi]
          |=> monitor_status_q[gi];
      endproperty
      a_ovf_status: assert property (p_ovf_status) else $error("overflow not reported"); // RULE_01
    end
  endgenerate

  property p_status_select;
    ##1 monitor_status_q == ($past(control_q.violation_or_overflow_select) ?
                             $past(overflow_w) : $past(line_code_violation));
  endproperty
  a_status_select: assert property (p_status_select) else $error("status source wrong"); // RULE_03

  property p_readback_off;
    (reg_req.addr == VCR_OFS_COUNT_BYTE) && !control_q.counter_readback_enable
      |=> (reg_rdata_q == VCR_BYTE_ZERO);
  endproperty
  a_readback_off: assert property (p_readback_off) else $error("readback while disabled"); // RULE_04

  property p_high_byte;
    (reg_req.addr == VCR_OFS_COUNT_BYTE) && control_q.counter_readback_enable && sel_ok_w &&
      reset_latch_q.byte_half_select
      |=> (reg_rdata_q == $past(sel_hold_w[15:8]));
  endproperty
  a_high_byte: assert property (p_high_byte) else $error("high byte wrong"); // RULE_09

  property p_low_byte;
    (reg_req.addr == VCR_OFS_COUNT_BYTE) && control_q.counter_readback_enable && sel_ok_w &&
      !reset_latch_q.byte_half_select
      |=> (reg_rdata_q == $past(sel_hold_w[7:0]));
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("low byte wrong"); // RULE_09

  property p_reset_all;
    reset_latch_q.reset_all_counters |=> (count_w == '0);
  endproperty
  a_reset_all: assert property (p_reset_all) else $error("global reset left a count"); // RULE_06

  property p_reset_one;
    reset_latch_q.reset_one_counter && sel_ok_w && $stable(control_q)
      |=> (count_w[control_q.counter_channel_select] == VCR_CNT_ZERO);
  endproperty
  a_reset_one: assert property (p_reset_one) else $error("channel reset failed"); // RULE_10

  property p_latch_all;
    reset_latch_q.latch_all_channels |=> (hold_q == $past(count_w));
  endproperty
  a_latch_all: assert property (p_latch_all) else $error("latch all missed"); // RULE_08

  property p_latch_one;
    reset_latch_q.latch_one_channel && sel_ok_w && $stable(control_q)
      |=> (hold_q[control_q.counter_channel_select] ==
           $past(count_w[control_q.counter_channel_select]));
  endproperty
  a_latch_one: assert property (p_latch_one) else $error("latch one missed"); // RULE_05

  c_saturate: cover property (overflow_w[0] && control_q.violation_or_overflow_select);
  c_read_high: cover property (control_q.counter_readback_enable && reset_latch_q.byte_half_select
                               && reg_req.addr == VCR_OFS_COUNT_BYTE);
  c_reset_all: cover property (reset_latch_q.reset_all_counters [*8]);
  c_latch_one: cover property (reset_latch_q.latch_one_channel && sel_ok_w);

endmodule // vcr_violation_counter_readback
`default_nettype wire

// [test/vcr_violation_counter_readback_tb.sv]
// self-checking testbench for the violation counter readback block
`timescale 1ns/100ps
`default_nettype none
module vcr_violation_counter_readback_tb
  import vcr_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus and bookkeeping
  // ----------------------------------------------------------------
  localparam int TIMEOUT_CYC = 90000; // saturation run alone takes about 66k cycles
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  vcr_reg_req_type reg_req = '0;
  logic [VCR_CHANNELS-1:0] line_code_violation = '0;
  logic [7:0] reg_rdata_q;
  logic [VCR_CHANNELS-1:0] monitor_status_q;
  logic [15:0] val;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;

  vcr_violation_counter_readback vcr_violation_counter_readback_inst (
    .sys_clk(sys_clk),
    .rst(rst),
    .reg_req(reg_req),
    .line_code_violation(line_code_violation),
    .reg_rdata_q(reg_rdata_q),
    .monitor_status_q(monitor_status_q)
  );

  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;

  // hang guard: a stuck run still reaches the verdict
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == TIMEOUT_CYC) begin
      error_cnt++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe, dropped on the following edge
  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    reg_req <= '{wr: 1'b1, addr: addr, wdata: data};
    @(posedge sys_clk);
    reg_req.wr <= 1'b0;
  endtask

  // read data is registered, so wait past the sampling edge
  task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
    @(posedge sys_clk);
    reg_req.addr <= addr;
    repeat (2) @(posedge sys_clk);
    #1 data = reg_rdata_q;
  endtask

  task automatic expect_reg(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    reg_read(addr, d);
    check({8'h00, d}, {8'h00, exp});
  endtask

  task automatic pulse(input logic [VCR_CHANNELS-1:0] mask, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      line_code_violation <= mask;
      @(posedge sys_clk);
      line_code_violation <= '0;
    end
  endtask

  // software keeps the reset bit up for the full microsecond
  task automatic hold_reset(input logic [7:0] bits);
    reg_write(VCR_OFS_RESET_LATCH, bits);
    repeat (VCR_RESET_HOLD_CYC) @(posedge sys_clk);
    reg_write(VCR_OFS_RESET_LATCH, 8'h00);
  endtask

  // select a channel, optionally latch it, then read both bytes
  task automatic read_count(input logic [3:0] ch, input bit lat, output logic [15:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    reg_write(VCR_OFS_CONTROL, 8'h40 | {4'h0, ch});
    if (lat) begin
      reg_write(VCR_OFS_RESET_LATCH, 8'h02);
      reg_write(VCR_OFS_RESET_LATCH, 8'h00);
    end
    reg_read(VCR_OFS_COUNT_BYTE, lo);
    reg_write(VCR_OFS_RESET_LATCH, 8'h04);
    reg_read(VCR_OFS_COUNT_BYTE, hi);
    reg_write(VCR_OFS_RESET_LATCH, 8'h00);
    v = {hi, lo};
  endtask

  task automatic end_of_test();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    expect_reg(VCR_OFS_CONTROL, VCR_CONTROL_RESET);
    expect_reg(VCR_OFS_RESET_LATCH, VCR_RESET_LATCH_RESET);
    expect_reg(VCR_OFS_COUNT_BYTE, VCR_BYTE_ZERO);
    expect_reg(8'hE7, 8'h00);
    reg_write(VCR_OFS_CONTROL, 8'h3A);
    expect_reg(VCR_OFS_CONTROL, 8'h3A);
    reg_write(VCR_OFS_RESET_LATCH, 8'hE4);
    expect_reg(VCR_OFS_RESET_LATCH, 8'hE4);
    reg_write(VCR_OFS_RESET_LATCH, 8'h00);
  endtask

  task automatic t_count_latch();
    pulse(14'h0008, 5);
    pulse(14'h0020, 2);
    read_count(4'h3, 1'b1, val);
    check(val, 16'h0005);
    read_count(4'h5, 1'b0, val);
    check(val, 16'h0000);
    reg_write(VCR_OFS_RESET_LATCH, 8'h08);
    reg_write(VCR_OFS_RESET_LATCH, 8'h00);
    read_count(4'h5, 1'b0, val);
    check(val, 16'h0002);
    reg_write(VCR_OFS_CONTROL, 8'h05);
    expect_reg(VCR_OFS_COUNT_BYTE, 8'h00);
    reg_write(VCR_OFS_CONTROL, 8'h4E);
    expect_reg(VCR_OFS_COUNT_BYTE, 8'h00);
  endtask

  // a violation every cycle drives channel 0 past full scale
  task automatic t_saturate();
    reg_write(VCR_OFS_CONTROL, 8'hC0);
    @(posedge sys_clk);
    line_code_violation <= 14'h0001;
    repeat (65540) @(posedge sys_clk);
    line_code_violation <= '0;
    repeat (2) @(posedge sys_clk);
    #1 check({2'b00, monitor_status_q}, 16'h0001);
    read_count(4'h0, 1'b1, val);
    check(val, 16'hFFFF);
    hold_reset(8'h01);
    read_count(4'h0, 1'b1, val);
    check(val, 16'h0000);
    read_count(4'h3, 1'b1, val);
    check(val, 16'h0005);
    hold_reset(8'h10);
    read_count(4'h3, 1'b1, val);
    check(val, 16'h0000);
    read_count(4'h5, 1'b1, val);
    check(val, 16'h0000);
  endtask

  task automatic t_monitor();
    reg_write(VCR_OFS_CONTROL, 8'h00);
    @(posedge sys_clk);
    line_code_violation <= 14'h0080;
    @(posedge sys_clk);
    line_code_violation <= '0;
    #1 check({2'b00, monitor_status_q}, 16'h0080);
    @(posedge sys_clk);
    #1 check({2'b00, monitor_status_q}, 16'h0000);
    reg_write(VCR_OFS_CONTROL, 8'h80);
    repeat (2) @(posedge sys_clk);
    #1 check({2'b00, monitor_status_q}, 16'h0000);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_count_latch();
    t_saturate();
    t_monitor();
    end_of_test();
  end
endmodule // vcr_violation_counter_readback_tb
`default_nettype wire
